// file: inc/dag_consts.svh
/*
  Constants of the data address generator: widths, reset values, step amounts.
  Assumes inclusion by the package and the design file only.
*/
`ifndef DAG_CONSTS_SVH
`define DAG_CONSTS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define DAG_AW 16
`define DAG_DISP_W 7
`define DAG_NREG 8

// ----------------------------------------
// reset values, step amounts and the port one circular select
// ----------------------------------------
`define DAG_WORD_RST 16'h0000
`define DAG_STEP_P3 16'h0003
`define DAG_STEP_P2 16'h0002
`define DAG_STEP_P1 16'h0001
`define DAG_STEP_Z 16'h0000
`define DAG_STEP_M1 16'hFFFF
`define DAG_STEP_M2 16'hFFFE
`define DAG_STEP_M3 16'hFFFD
`define DAG_P1_CIRC_SEL 2'h3

`endif

// file: inc/dag_pkg.sv
/*
  Types of the data address generator: step codes, register targets, requests.
  Assumes dag_consts.svh is on the include path.
*/
`include "dag_consts.svh"

package dag_pkg;

  typedef logic [`DAG_AW-1:0] dag_word_t;

  // port zero post-modify choices
  typedef enum logic [1:0] {
    DAG_P0_INC1 = 2'h0,
    DAG_P0_HOLD = 2'h1,
    DAG_P0_DEC1 = 2'h2,
    DAG_P0_STEP0 = 2'h3
  } dag_p0_step_e;

  // port one post-modify choices
  typedef enum logic [2:0] {
    DAG_P1_INC3 = 3'h0, DAG_P1_INC2 = 3'h1, DAG_P1_INC1 = 3'h2, DAG_P1_HOLD = 3'h3,
    DAG_P1_DEC1 = 3'h4, DAG_P1_DEC2 = 3'h5, DAG_P1_DEC3 = 3'h6, DAG_P1_STEP1 = 3'h7
  } dag_p1_step_e;

  // port two post-modify choices
  typedef enum logic [2:0] {
    DAG_P2_INC2 = 3'h0, DAG_P2_INC1 = 3'h1, DAG_P2_HOLD = 3'h2, DAG_P2_DEC1 = 3'h3,
    DAG_P2_DEC2 = 3'h4, DAG_P2_DEC3 = 3'h5, DAG_P2_STEP0 = 3'h6, DAG_P2_STEP1 = 3'h7
  } dag_p2_step_e;

  // targets of the load / readback port
  typedef enum logic [3:0] {
    DAG_R_X0 = 4'h0, DAG_R_X1 = 4'h1, DAG_R_X2 = 4'h2, DAG_R_X3 = 4'h3,
    DAG_R_X4 = 4'h4, DAG_R_X5 = 4'h5, DAG_R_X6 = 4'h6, DAG_R_X7 = 4'h7,
    DAG_R_STEP0 = 4'h8, DAG_R_STEP1 = 4'h9, DAG_R_COFS = 4'hA,
    DAG_R_MOD = 4'hB, DAG_R_BASE = 4'hC
  } dag_reg_e;

  typedef struct packed {
    logic valid;
    dag_word_t immediate_address;
  } dag_dir_req_s;

  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    dag_p0_step_e step;
  } dag_p0_req_s;

  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    dag_p1_step_e step;
  } dag_p1_req_s;

  typedef struct packed {
    logic valid;
    logic base_mode;
    logic circular;
    logic [2:0] sel;
    dag_p2_step_e step;
    logic [`DAG_DISP_W-1:0] signed_displacement;
  } dag_p2_req_s;

  typedef struct packed {
    logic valid;
    dag_reg_e target;
    dag_word_t data;
  } dag_wr_req_s;

  typedef struct packed {
    logic valid;
    dag_word_t addr;
  } dag_addr_s;

endpackage

// file: src/dag_top.sv
/*
  Data address generator: word addresses for direct, indirect, base plus
  displacement and circular operands on three indirect ports.
  Assumes requests come from the instruction decoder on CLK, and that the
  data memory takes the registered effective addresses one cycle later.
*/
`include "dag_consts.svh"

module dag_top
  import dag_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input dag_dir_req_s DIR_REQ,
  input dag_p0_req_s P0_REQ,
  input dag_p1_req_s P1_REQ,
  input dag_p2_req_s P2_REQ,
  input dag_wr_req_s WR_REQ,
  input dag_reg_e RD_SEL,
  output dag_addr_s DIR_ADDR,
  output dag_addr_s ADDR0,
  output dag_addr_s ADDR1,
  output dag_addr_s ADDR2,
  output dag_word_t RD_DATA
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // post-modify; circular wrap only corrects once, so steps must not exceed the range
  // the sum is two bits wider so a step below zero stays visible before the wrap
  function automatic dag_word_t post_mod(dag_word_t cur, dag_word_t step, logic circ,
                                          dag_word_t md);
    logic signed [17:0] sum;
    sum = $signed({2'b00, cur}) + $signed({{2{step[15]}}, step});
    if (circ && (md != `DAG_WORD_RST))
    begin
      if (sum < 0)
        sum = sum + $signed({2'b00, md});
      else if (sum >= $signed({2'b00, md}))
        sum = sum - $signed({2'b00, md});
    end
    return sum[15:0];
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  // address registers kept as an array so every port can index them directly
  dag_word_t addr_reg [`DAG_NREG];
  dag_word_t addr_next [`DAG_NREG];
  dag_word_t step0_reg, step0_next;
  dag_word_t step1_reg, step1_next;
  dag_word_t cofs_reg, cofs_next;
  dag_word_t mod_reg, mod_next;
  dag_word_t base_reg, base_next;
  dag_addr_s dir_reg, dir_next;
  dag_addr_s addr0_reg, addr0_next;
  dag_addr_s addr1_reg, addr1_next;
  dag_addr_s addr2_reg, addr2_next;
  dag_word_t rd_reg, rd_next;

  // per-port results
  logic [2:0] p0_idx, p1_idx, p2_idx;
  logic p1_circ, p2_upd;
  dag_word_t p0_step, p1_step, p2_step;
  dag_word_t p0_new, p1_new, p2_new;
  dag_word_t p0_ea, p1_ea, p2_ea;

  // ----------------------------------------
  // port zero
  // ----------------------------------------

  // only registers zero to three reach this port, never circular
  always_comb
  begin
    p0_idx = {1'b0, P0_REQ.sel};
    case (P0_REQ.step)
      DAG_P0_INC1: p0_step = `DAG_STEP_P1;
      DAG_P0_HOLD: p0_step = `DAG_STEP_Z;
      DAG_P0_DEC1: p0_step = `DAG_STEP_M1;
      DAG_P0_STEP0: p0_step = step0_reg;
      default: p0_step = `DAG_STEP_Z;
    endcase
    p0_ea = addr_reg[p0_idx];
    p0_new = post_mod(addr_reg[p0_idx], p0_step, 1'b0, mod_reg);
  end

  // ----------------------------------------
  // port one
  // ----------------------------------------

  // selecting register seven turns circular mode on by itself
  always_comb
  begin
    p1_idx = {1'b1, P1_REQ.sel};
    p1_circ = (P1_REQ.sel == `DAG_P1_CIRC_SEL);
    case (P1_REQ.step)
      DAG_P1_INC3: p1_step = `DAG_STEP_P3;
      DAG_P1_INC2: p1_step = `DAG_STEP_P2;
      DAG_P1_INC1: p1_step = `DAG_STEP_P1;
      DAG_P1_HOLD: p1_step = `DAG_STEP_Z;
      DAG_P1_DEC1: p1_step = `DAG_STEP_M1;
      DAG_P1_DEC2: p1_step = `DAG_STEP_M2;
      DAG_P1_DEC3: p1_step = `DAG_STEP_M3;
      DAG_P1_STEP1: p1_step = step1_reg;
      default: p1_step = `DAG_STEP_Z;
    endcase
    // zero offset and zero modulo fall through to plain indirect
    if (p1_circ)
      p1_ea = cofs_reg + addr_reg[p1_idx];
    else
      p1_ea = addr_reg[p1_idx];
    // step register one is signed, so a large value walks the pointer backwards
    p1_new = post_mod(addr_reg[p1_idx], p1_step, p1_circ, mod_reg);
  end

  // ----------------------------------------
  // port two
  // ----------------------------------------

  // base mode touches no register; otherwise any register, optionally circular
  always_comb
  begin
    p2_idx = P2_REQ.sel;
    p2_upd = P2_REQ.valid && !P2_REQ.base_mode;
    case (P2_REQ.step)
      DAG_P2_INC2: p2_step = `DAG_STEP_P2;
      DAG_P2_INC1: p2_step = `DAG_STEP_P1;
      DAG_P2_HOLD: p2_step = `DAG_STEP_Z;
      DAG_P2_DEC1: p2_step = `DAG_STEP_M1;
      DAG_P2_DEC2: p2_step = `DAG_STEP_M2;
      DAG_P2_DEC3: p2_step = `DAG_STEP_M3;
      DAG_P2_STEP0: p2_step = step0_reg;
      DAG_P2_STEP1: p2_step = step1_reg;
      default: p2_step = `DAG_STEP_Z;
    endcase
    if (P2_REQ.base_mode)
      p2_ea = base_reg + {{(`DAG_AW-`DAG_DISP_W){P2_REQ.signed_displacement[6]}},
                          P2_REQ.signed_displacement};
    else if (P2_REQ.circular)
      p2_ea = cofs_reg + addr_reg[p2_idx];
    else
      p2_ea = addr_reg[p2_idx];
    // computed in base mode too, but p2_upd keeps it from landing
    p2_new = post_mod(addr_reg[p2_idx], p2_step, P2_REQ.circular, mod_reg);
  end

  // ----------------------------------------
  // address registers
  // ----------------------------------------

  // later assignments win: port zero, one, two, then the decoder load
  // a write on the same cycle as a post-modify is the one that sticks
  for (genvar i = 0; i < `DAG_NREG; i++)
  begin : g_areg
    // entry number cut to the width of the selects and of the load target
    localparam logic [2:0] entry_idx = 3'(i);
    localparam dag_reg_e entry_code = dag_reg_e'(4'(i));

    always_comb
    begin
      addr_next[i] = addr_reg[i];
      if (P0_REQ.valid && (p0_idx == entry_idx))
        addr_next[i] = p0_new;
      if (P1_REQ.valid && (p1_idx == entry_idx))
        addr_next[i] = p1_new;
      if (p2_upd && (p2_idx == entry_idx))
        addr_next[i] = p2_new;
      if (WR_REQ.valid && (WR_REQ.target == entry_code))
        addr_next[i] = WR_REQ.data;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        addr_reg[i] <= `DAG_WORD_RST;
      else
        addr_reg[i] <= addr_next[i];
    end
  end

  // ----------------------------------------
  // step, offset, modulo and base registers
  // ----------------------------------------

  // loaded only from the decoder; no port ever modifies them
  always_comb
  begin
    step0_next = step0_reg;
    step1_next = step1_reg;
    cofs_next = cofs_reg;
    mod_next = mod_reg;
    base_next = base_reg;
    if (WR_REQ.valid)
    begin
      case (WR_REQ.target)
        DAG_R_STEP0: step0_next = WR_REQ.data;
        DAG_R_STEP1: step1_next = WR_REQ.data;
        DAG_R_COFS: cofs_next = WR_REQ.data;
        DAG_R_MOD: mod_next = WR_REQ.data;
        DAG_R_BASE: base_next = WR_REQ.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      step0_reg <= `DAG_WORD_RST;
      step1_reg <= `DAG_WORD_RST;
      cofs_reg <= `DAG_WORD_RST;
      mod_reg <= `DAG_WORD_RST;
      base_reg <= `DAG_WORD_RST;
    end
    else
    begin
      step0_reg <= step0_next;
      step1_reg <= step1_next;
      cofs_reg <= cofs_next;
      mod_reg <= mod_next;
      base_reg <= base_next;
    end
  end

  // ----------------------------------------
  // effective addresses and readback
  // ----------------------------------------

  // outputs are word addresses; memory never sees a byte offset
  always_comb
  begin
    dir_next.valid = DIR_REQ.valid;
    dir_next.addr = DIR_REQ.immediate_address;
    // valid just follows the request; no port ever refuses one
    addr0_next.valid = P0_REQ.valid;
    addr0_next.addr = p0_ea;
    addr1_next.valid = P1_REQ.valid;
    addr1_next.addr = p1_ea;
    addr2_next.valid = P2_REQ.valid;
    addr2_next.addr = p2_ea;
    case (RD_SEL)
      DAG_R_STEP0: rd_next = step0_reg;
      DAG_R_STEP1: rd_next = step1_reg;
      DAG_R_COFS: rd_next = cofs_reg;
      DAG_R_MOD: rd_next = mod_reg;
      DAG_R_BASE: rd_next = base_reg;
      default:
      begin
        // codes past the base pointer have no register behind them
        if (RD_SEL[3])
          rd_next = `DAG_WORD_RST;
        else
          rd_next = addr_reg[RD_SEL[2:0]];
      end
    endcase
  end

  // registered so the memory sees a clean address at the clock edge
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dir_reg <= '0;
      addr0_reg <= '0;
      addr1_reg <= '0;
      addr2_reg <= '0;
      rd_reg <= `DAG_WORD_RST;
    end
    else
    begin
      dir_reg <= dir_next;
      addr0_reg <= addr0_next;
      addr1_reg <= addr1_next;
      addr2_reg <= addr2_next;
      rd_reg <= rd_next;
    end
  end

  assign DIR_ADDR = dir_reg;
  assign ADDR0 = addr0_reg;
  assign ADDR1 = addr1_reg;
  assign ADDR2 = addr2_reg;
  assign RD_DATA = rd_reg;

endmodule

// file: dv/dag_checker_assertions.sv
/*
  Port checker of the data address generator.
  Assumes it is bound onto dag_top and sees only its ports.
*/
module dag_checker
  import dag_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input dag_dir_req_s DIR_REQ,
  input dag_p0_req_s P0_REQ,
  input dag_p1_req_s P1_REQ,
  input dag_p2_req_s P2_REQ,
  input dag_wr_req_s WR_REQ,
  input dag_reg_e RD_SEL,
  input dag_addr_s DIR_ADDR,
  input dag_addr_s ADDR0,
  input dag_addr_s ADDR1,
  input dag_addr_s ADDR2,
  input dag_word_t RD_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // timing of every port is one cycle
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_DIR_ADDR: assert property (
    DIR_REQ.valid |=> DIR_ADDR.valid && DIR_ADDR.addr == $past(DIR_REQ.immediate_address))
    else $error("direct address wrong");
  AST_IDLE_QUIET: assert property (
    !(DIR_REQ.valid || P0_REQ.valid || P1_REQ.valid || P2_REQ.valid)
    |=> !(DIR_ADDR.valid || ADDR0.valid || ADDR1.valid || ADDR2.valid))
    else $error("address without request");
  AST_P0_VALID: assert property (P0_REQ.valid |=> ADDR0.valid)
    else $error("port zero gave no address");
  AST_P1_VALID: assert property (P1_REQ.valid |=> ADDR1.valid)
    else $error("port one gave no address");
  AST_P2_VALID: assert property (P2_REQ.valid |=> ADDR2.valid)
    else $error("port two gave no address");
  // write and port two may overrule port zero, so they are kept out
  AST_P0_INC: assert property (
    P0_REQ.valid && P0_REQ.step == DAG_P0_INC1 && !WR_REQ.valid && !P2_REQ.valid
    ##1 P0_REQ.valid && P0_REQ.sel == $past(P0_REQ.sel)
    |=> ADDR0.addr == $past(ADDR0.addr) + 16'h0001)
    else $error("port zero increment wrong");
  AST_P0_HOLD: assert property (
    P0_REQ.valid && P0_REQ.step == DAG_P0_HOLD && !WR_REQ.valid && !P2_REQ.valid
    ##1 P0_REQ.valid && P0_REQ.sel == $past(P0_REQ.sel)
    |=> $stable(ADDR0.addr))
    else $error("port zero hold moved");
  AST_P1_HOLD: assert property (
    P1_REQ.valid && P1_REQ.sel != 2'h3 && P1_REQ.step == DAG_P1_HOLD && !WR_REQ.valid
    && !P2_REQ.valid ##1 P1_REQ.valid && P1_REQ.sel == $past(P1_REQ.sel)
    |=> $stable(ADDR1.addr))
    else $error("port one hold moved");
endmodule

bind dag_top dag_checker u_chk (.CLK, .RST_N, .DIR_REQ, .P0_REQ, .P1_REQ, .P2_REQ,
  .WR_REQ, .RD_SEL, .DIR_ADDR, .ADDR0, .ADDR1, .ADDR2, .RD_DATA);

// file: dv/dag_mem_model.sv
/*
  Data memory side model: counts word accesses.
  Assumes the registered address outputs of the generator.
*/
module dag_mem_model
  import dag_pkg::*;
(
  input wire logic clk,
  input dag_addr_s dir_addr,
  input dag_addr_s addr0,
  input dag_addr_s addr1,
  input dag_addr_s addr2,
  output int n_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // one whole word per valid address, there are no byte lanes; one process owns the count
  initial
  begin
    n_word = 0;
    forever
    begin
      @(posedge clk);
      n_word <= n_word + dir_addr.valid + addr0.valid + addr1.valid + addr2.valid;
    end
  end
endmodule

// file: dv/data_address_generator_test.sv
/*
  Self-checking bench of the data address generator.
  Assumes dag_top, the checker and the memory model are compiled first.
*/
module data_address_generator_test
  import dag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_n;
  dag_dir_req_s dir_req;
  dag_p0_req_s p0_req;
  dag_p1_req_s p1_req;
  dag_p2_req_s p2_req;
  dag_wr_req_s wr_req;
  dag_reg_e rd_sel;
  dag_addr_s dir_addr, addr0, addr1, addr2;
  dag_word_t rd_data;
  int n_mismatch, compares, exp_acc, n_word;

  dag_top dut (.CLK(clk), .RST_N(rst_n), .DIR_REQ(dir_req), .P0_REQ(p0_req),
    .P1_REQ(p1_req), .P2_REQ(p2_req), .WR_REQ(wr_req), .RD_SEL(rd_sel),
    .DIR_ADDR(dir_addr), .ADDR0(addr0), .ADDR1(addr1), .ADDR2(addr2), .RD_DATA(rd_data));
  dag_mem_model mem (.clk(clk), .dir_addr(dir_addr), .addr0(addr0), .addr1(addr1),
    .addr2(addr2), .n_word(n_word));

  // ----------------------------------------
  // clock, helpers
  // ----------------------------------------
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // inputs move 1 ns after the edge so sampling never races
  task cyc;
    @(posedge clk);
    #1;
  endtask

  task chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task idle;
    dir_req = '0;
    p0_req = '0;
    p1_req = '0;
    p2_req = '0;
    wr_req = '0;
    cyc;
  endtask

  task wr(input dag_reg_e t, input dag_word_t d);
    wr_req = '{1'b1, t, d};
    cyc;
  endtask

  task rd(input dag_reg_e t, input dag_word_t e);
    rd_sel = t;
    cyc;
    chk("readback", {1'b0, rd_data}, {1'b0, e});
  endtask

  // requests stay up between calls, so back to back transfers need no gap
  task p0(input logic [1:0] s, input dag_p0_step_e st, input dag_word_t e);
    p0_req = '{1'b1, s, st};
    cyc;
    exp_acc++;
    chk("port0", addr0, {1'b1, e});
  endtask

  task p1(input logic [1:0] s, input dag_p1_step_e st, input dag_word_t e);
    p1_req = '{1'b1, s, st};
    cyc;
    exp_acc++;
    chk("port1", addr1, {1'b1, e});
  endtask

  task p2(input logic b, input logic c, input logic [2:0] s, input dag_p2_step_e st,
    input logic [6:0] dp, input dag_word_t e);
    p2_req = '{1'b1, b, c, s, st, dp};
    cyc;
    exp_acc++;
    chk("port2", addr2, {1'b1, e});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_direct;
    wr(DAG_R_X0, 16'h1234);
    idle;
    dir_req = '{1'b1, 16'hbeef};
    cyc;
    exp_acc++;
    chk("direct", dir_addr, {1'b1, 16'hbeef});
    dir_req = '0;
    rd(DAG_R_X0, 16'h1234);
  endtask

  // offset loaded first: port zero must still ignore it
  task t_p0;
    wr(DAG_R_COFS, 16'h0050);
    wr(DAG_R_STEP0, 16'h0005);
    wr(DAG_R_X1, 16'hffff);
    wr(DAG_R_X2, 16'h0010);
    idle;
    p0(2'h2, DAG_P0_INC1, 16'h0010);
    p0(2'h2, DAG_P0_HOLD, 16'h0011);
    p0(2'h2, DAG_P0_DEC1, 16'h0011);
    p0(2'h2, DAG_P0_STEP0, 16'h0010);
    p0(2'h2, DAG_P0_INC1, 16'h0015);
    p0(2'h1, DAG_P0_INC1, 16'hffff);
    p0(2'h1, DAG_P0_HOLD, 16'h0000);
    idle;
  endtask

  task t_p1;
    dag_word_t e;
    wr(DAG_R_X4, 16'h0100);
    wr(DAG_R_STEP1, 16'hfffe);
    idle;
    e = 16'h0100;
    for (int i = 0; i < 8; i++)
    begin
      p1(2'h0, dag_p1_step_e'(i[2:0]), e);
      e = e + ((i == 7) ? 16'hfffe : 16'(3 - i));
    end
    idle;
    wr(DAG_R_COFS, 16'h0005);
    wr(DAG_R_MOD, 16'h0004);
    wr(DAG_R_X7, 16'h0002);
    idle;
    p1(2'h3, DAG_P1_INC1, 16'h0007);
    p1(2'h3, DAG_P1_INC1, 16'h0008);
    p1(2'h3, DAG_P1_INC1, 16'h0005);
    idle;
    rd(DAG_R_X7, 16'h0001);
    wr(DAG_R_COFS, 16'h0000);
    wr(DAG_R_MOD, 16'h0000);
    wr(DAG_R_X7, 16'h0200);
    idle;
    p1(2'h3, DAG_P1_DEC3, 16'h0200);
    p1(2'h3, DAG_P1_HOLD, 16'h01fd);
    idle;
  endtask

  task t_p2;
    dag_word_t e;
    wr(DAG_R_BASE, 16'h1000);
    wr(DAG_R_X5, 16'h0040);
    wr(DAG_R_COFS, 16'h0020);
    wr(DAG_R_MOD, 16'h0008);
    wr(DAG_R_X3, 16'h0006);
    idle;
    p2(1'b1, 1'b0, 3'h5, DAG_P2_INC2, 7'h40, 16'h0fc0);
    p2(1'b1, 1'b0, 3'h5, DAG_P2_INC2, 7'h3f, 16'h103f);
    e = 16'h0040;
    for (int i = 0; i < 8; i++)
    begin
      p2(1'b0, 1'b0, 3'h5, dag_p2_step_e'(i[2:0]), 7'h00, e);
      e = e + ((i == 6) ? 16'h0005 : (i == 7) ? 16'hfffe : 16'(2 - i));
    end
    p2(1'b0, 1'b1, 3'h3, DAG_P2_INC2, 7'h00, 16'h0026);
    p2(1'b0, 1'b1, 3'h3, DAG_P2_INC2, 7'h00, 16'h0020);
    idle;
  endtask

  // step, offset, modulo, base and register five read back, then a reset in mid-run must clear base and register five
  task t_reset;
    rd(DAG_R_STEP0, 16'h0005);
    rd(DAG_R_STEP1, 16'hfffe);
    rd(DAG_R_COFS, 16'h0020);
    rd(DAG_R_MOD, 16'h0008);
    rd(DAG_R_X5, 16'h0040);
    rd(DAG_R_BASE, 16'h1000);
    rst_n = 0;
    cyc;
    chk("reset_rd", {1'b0, rd_data}, 17'h0_0000);
    chk("reset_addr2", addr2, 17'h0_0000);
    rst_n = 1;
    rd(DAG_R_BASE, 16'h0000);
    rd(DAG_R_X5, 16'h0000);
    rd(dag_reg_e'(4'hE), 16'h0000);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task summarize;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    rst_n = 0;
    dir_req = '0;
    p0_req = '0;
    p1_req = '0;
    p2_req = '0;
    wr_req = '0;
    rd_sel = DAG_R_X0;
    n_mismatch = 0;
    compares = 0;
    exp_acc = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    t_direct;
    t_p0;
    t_p1;
    t_p2;
    t_reset;
    chk("words", 17'(n_word), 17'(exp_acc));
    summarize;
  end

  // the tests take about 90 cycles; this cuts a hang short
  initial
  begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    summarize;
  end
endmodule
